// ===== inc/icf_pkg.sv
package icf_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RA0 = 8'h04;
  localparam logic [7:0] OFF_RA1 = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  // ==========================================
  // cache_control_word fields
  localparam int CW_EN = 31;
  localparam int CW_LINV_DIS = 28;
  localparam int CW_INV_ALL = 24;
  localparam int CW_NC_BURST = 10;
  localparam int CW_DEF_NC = 9;
  localparam int CW_DEF_BUF = 8;
  localparam int CW_DEF_WP = 5;
  localparam int CW_LNF = 0;
  localparam logic [31:0] CW_MASK = 32'h9000_0723;
  localparam logic [31:0] CW_RESET = 32'h0000_0000;
  // ==========================================
  // region_attr_reg fields
  localparam int RA_BASE = 24;
  localparam int RA_AMASK = 16;
  localparam int RA_EN = 15;
  localparam int RA_NC = 6;
  localparam int RA_BUF = 5;
  localparam int RA_WP = 2;
  localparam logic [31:0] RA_MASK = 32'hFFFF_8064;
  localparam logic [31:0] RA_RESET = 32'h0000_0000;
  // ==========================================
  // status fields
  localparam int ST_FB_VAL = 0;
  localparam int ST_FB_NC = 5;
  localparam int ST_MRU = 6;
  localparam int ST_BUSY = 7;
  // ==========================================
  // geometry and sizes
  localparam int INV_CYCLES = 256;
  localparam int LINES = 256;
  localparam int WORDS = 1024;
  localparam logic [7:0] INV_LAST = 8'(INV_CYCLES - 1);
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_WB = 3'b010,
    ST_EXT = 3'b011,
    ST_INV = 3'b100
  } icf_state_t;

  typedef struct packed {
    logic nc;
    logic buffered;
    logic wprot;
  } icf_attr_t;
endpackage

// ===== inc/icf_match_if.sv
`timescale 1ns/1ps
interface icf_match_if;
  logic [31:0] addr;
  logic [31:0] region;
  logic hit;
  icf_pkg::icf_attr_t attr;
  modport matcher (input addr, input region, output hit, output attr);
  modport user (output addr, output region, input hit, input attr);
endinterface // icf_match_if

// ===== core/icf_region_match.sv
`timescale 1ns/1ps
module icf_region_match (
  icf_match_if.matcher m
);
  // mask bits set mean "don't care" for that address bit
  assign m.hit = m.region[icf_pkg::RA_EN] &&
                 (((m.addr[31:24] ^ m.region[icf_pkg::RA_BASE +: 8]) &
                   ~m.region[icf_pkg::RA_AMASK +: 8]) == 8'h00);
  assign m.attr = {m.region[icf_pkg::RA_NC], m.region[icf_pkg::RA_BUF],
                   m.region[icf_pkg::RA_WP]};
endmodule // icf_region_match

// ===== core/icf_cache_ctrl.sv
// Function
// - sram-mapped fetch: cache output discarded, no external reference.
// - region 0 first, then region 1, else default attributes.
// - attributes: cacheable, buffered write, write protect.
// - control bit 24 invalidates all tags, one per cycle, 256 cycles.
// - fetches stall while whole-cache invalidation runs.
// - line invalidate clears tag at source bits 11:4 unless bit 28 set.
// - both invalidations accepted from core or debug.
// - reset clears control word; tag array untouched.
// - enabled cacheable miss in tags and buffer starts external fetch.
// - fetch size from line-fill select and miss longword offset.
// - line fetch critical longword first, then wrap modulo 16 bytes.
// - miss loading fill buffer marks buffer most recently used.
// - array hit at buffer address bits 8:4 clears recency indicator.
// - next miss writes back full buffer if still most recent.
// - noncacheable burst loads buffer, never written into array.
// - cache disabled: all fetches word or longword.
// - enabled, no burst: noncacheable is single longword, buffer kept.
// - select at bits 1:0, burst enable bit 10, enable bit 31.
// - sram-mapped references skip region matching.
`timescale 1ns/1ps
module icf_cache_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_word,
  input wire logic fetch_sram,
  output logic fetch_rdy,
  output logic fetch_ack,
  output logic [31:0] fetch_data,
  output logic ref_cacheable,
  output logic ref_buffered,
  output logic ref_wprot,
  input wire logic dbg_inv_all,
  input wire logic line_inv_core,
  input wire logic [31:0] line_inv_core_addr,
  input wire logic line_inv_dbg,
  input wire logic [31:0] line_inv_dbg_addr,
  output logic ext_req,
  output logic [31:0] ext_addr,
  output logic [1:0] ext_size,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata
);
  // ==========================================
  // declarations
  icf_pkg::icf_state_t state;
  logic [31:0] cw, ra0, ra1, stat;
  logic [20:0] tag_mem [icf_pkg::LINES];
  logic [31:0] data_mem [icf_pkg::WORDS];
  logic [20:0] tag_q, tag_wd;
  logic [31:0] data_q;
  logic tag_we;
  logic [7:0] tag_wa, inv_cnt, line_idx;
  logic inv_all_pend, line_pend;
  logic [31:0] req_addr;
  logic req_word, req_sram;
  icf_pkg::icf_attr_t attr_q, dflt_attr, eff_attr;
  logic [27:0] fb_line;
  logic [31:0] fb_data [4];
  logic [3:0] fb_val;
  logic fb_nc, fb_load, mru;
  logic [1:0] beat, wb_cnt;
  logic en, nc_burst;
  logic [1:0] lnf;
  logic look_fbh, look_arr, look_miss, miss_load, miss_line, miss_wb;
  logic beat_ok, last_beat, ext_start, idle_free, conc_ok, fetch_take;

  icf_match_if mi0 ();
  icf_match_if mi1 ();

  // ==========================================
  // effective attributes
  assign en = cw[icf_pkg::CW_EN];
  assign nc_burst = cw[icf_pkg::CW_NC_BURST];
  assign lnf = cw[icf_pkg::CW_LNF +: 2];
  assign mi0.addr = fetch_addr;
  assign mi0.region = ra0;
  assign mi1.addr = fetch_addr;
  assign mi1.region = ra1;
  icf_region_match u_match0 (.m(mi0));
  icf_region_match u_match1 (.m(mi1));
  assign dflt_attr = {cw[icf_pkg::CW_DEF_NC], cw[icf_pkg::CW_DEF_BUF], cw[icf_pkg::CW_DEF_WP]};
  // sram-mapped references never consult the region registers
  assign eff_attr = fetch_sram ? dflt_attr :
                    mi0.hit ? mi0.attr : mi1.hit ? mi1.attr : dflt_attr;

  // ==========================================
  // lookup and miss decisions
  assign look_fbh = en && req_addr[31:4] == fb_line && fb_val[req_addr[3:2]];
  assign look_arr = en && !attr_q.nc && tag_q[20] && tag_q[19:0] == req_addr[31:12];
  assign look_miss = !req_sram && !look_fbh && !look_arr;
  assign miss_load = en && !(attr_q.nc && !nc_burst);
  assign miss_line = miss_load && (lnf[1] ||
                     (lnf[0] ? !req_addr[3] : req_addr[3:2] != 2'h3));
  assign miss_wb = en && fb_val == 4'hF && mru && !fb_nc;
  assign ext_req = state == icf_pkg::ST_EXT;
  assign beat_ok = ext_req && ext_ack;
  assign last_beat = ext_size != icf_pkg::SZ_LINE || beat == 2'h3;
  assign ext_start = (state == icf_pkg::ST_LOOK && look_miss && !miss_wb && miss_load) ||
                     (state == icf_pkg::ST_WB && wb_cnt == 2'h3 && fb_load);

  // ==========================================
  // request acceptance
  // a stall here is how pending invalidations hold the core off
  assign idle_free = state == icf_pkg::ST_IDLE && !inv_all_pend && !line_pend;
  // buffer hits are served while the rest of the line is still arriving
  assign conc_ok = ext_req && fb_load && beat != 2'h0 && en && !fetch_sram &&
                   !inv_all_pend && fetch_addr[31:4] == fb_line && fb_val[fetch_addr[3:2]];
  assign fetch_rdy = idle_free || conc_ok;
  assign fetch_take = fetch_req && fetch_rdy;

  always_ff @(posedge clk) begin
    if (reset) begin
      req_addr <= 32'h0000_0000;
      req_word <= 1'b0;
      req_sram <= 1'b0;
      attr_q <= 3'h0;
      ref_cacheable <= 1'b0;
      ref_buffered <= 1'b0;
      ref_wprot <= 1'b0;
    end else if (fetch_take) begin
      if (idle_free) begin
        req_addr <= fetch_addr;
        req_word <= fetch_word;
        req_sram <= fetch_sram;
        attr_q <= eff_attr;
      end
      ref_cacheable <= !eff_attr.nc;
      ref_buffered <= eff_attr.buffered;
      ref_wprot <= eff_attr.wprot;
    end
  end

  // ==========================================
  // answer to the core
  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_ack <= 1'b0;
      fetch_data <= 32'h0000_0000;
    end else begin
      fetch_ack <= 1'b0;
      if (state == icf_pkg::ST_LOOK && !req_sram && (look_fbh || look_arr)) begin
        fetch_ack <= 1'b1;
        fetch_data <= look_fbh ? fb_data[req_addr[3:2]] : data_q;
      end else if (beat_ok && beat == 2'h0) begin
        fetch_ack <= 1'b1;
        fetch_data <= ext_rdata;
      end else if (fetch_take && conc_ok) begin
        fetch_ack <= 1'b1;
        fetch_data <= fb_data[fetch_addr[3:2]];
      end
    end
  end

  // ==========================================
  // sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= icf_pkg::ST_IDLE;
      inv_cnt <= 8'h00;
      beat <= 2'h0;
      wb_cnt <= 2'h0;
      fb_load <= 1'b0;
      ext_size <= icf_pkg::SZ_LONG;
      ext_addr <= 32'h0000_0000;
    end else begin
      case (state)
        icf_pkg::ST_IDLE: begin
          if (inv_all_pend) begin
            state <= icf_pkg::ST_INV;
            inv_cnt <= 8'h00;
          end else if (fetch_take) begin
            state <= icf_pkg::ST_LOOK;
          end
        end
        icf_pkg::ST_LOOK: begin
          if (!look_miss) begin
            state <= icf_pkg::ST_IDLE;
          end else begin
            beat <= 2'h0;
            wb_cnt <= 2'h0;
            fb_load <= miss_load;
            if (!en) begin
              ext_size <= req_word ? icf_pkg::SZ_WORD : icf_pkg::SZ_LONG;
            end else begin
              ext_size <= miss_line ? icf_pkg::SZ_LINE : icf_pkg::SZ_LONG;
            end
            ext_addr <= (!en && req_word) ? req_addr : {req_addr[31:2], 2'h0};
            state <= miss_wb ? icf_pkg::ST_WB : icf_pkg::ST_EXT;
          end
        end
        icf_pkg::ST_WB: begin
          wb_cnt <= wb_cnt + 2'h1;
          if (wb_cnt == 2'h3) begin
            state <= icf_pkg::ST_EXT;
          end
        end
        icf_pkg::ST_EXT: begin
          if (beat_ok) begin
            beat <= beat + 2'h1;
            ext_addr[3:2] <= ext_addr[3:2] + 2'h1;
            if (last_beat) begin
              state <= icf_pkg::ST_IDLE;
            end
          end
        end
        icf_pkg::ST_INV: begin
          inv_cnt <= inv_cnt + 8'h01;
          if (inv_cnt == icf_pkg::INV_LAST) begin
            state <= icf_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= icf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // invalidation requests
  always_ff @(posedge clk) begin
    if (reset) begin
      inv_all_pend <= 1'b0;
      line_pend <= 1'b0;
      line_idx <= 8'h00;
    end else begin
      if (state == icf_pkg::ST_IDLE && inv_all_pend) begin
        inv_all_pend <= 1'b0;
      end
      if (state == icf_pkg::ST_IDLE && !inv_all_pend && line_pend) begin
        line_pend <= 1'b0;
      end
      // new requests are set after the clears so a coincident one survives
      if (dbg_inv_all || (reg_wr && reg_addr == icf_pkg::OFF_CTRL &&
          reg_wdata[icf_pkg::CW_INV_ALL])) begin
        inv_all_pend <= 1'b1;
      end
      if ((line_inv_core || line_inv_dbg) && !cw[icf_pkg::CW_LINV_DIS]) begin
        line_pend <= 1'b1;
        // core wins if both arrive together
        line_idx <= line_inv_core ? line_inv_core_addr[11:4] : line_inv_dbg_addr[11:4];
      end
    end
  end

  // ==========================================
  // tag and data arrays
  always_comb begin
    tag_we = 1'b0;
    tag_wa = inv_cnt;
    tag_wd = 21'h0_0000;
    if (state == icf_pkg::ST_INV) begin
      tag_we = 1'b1;
    end else if (state == icf_pkg::ST_IDLE && !inv_all_pend && line_pend) begin
      tag_we = 1'b1;
      tag_wa = line_idx;
    end else if (state == icf_pkg::ST_WB && wb_cnt == 2'h3) begin
      tag_we = 1'b1;
      tag_wa = fb_line[7:0];
      tag_wd = {1'b1, fb_line[27:8]};
    end
  end

  // arrays have no reset so contents survive it
  always_ff @(posedge clk) begin
    tag_q <= tag_mem[fetch_addr[11:4]];
    data_q <= data_mem[fetch_addr[11:2]];
    if (tag_we) begin
      tag_mem[tag_wa] <= tag_wd;
    end
    if (state == icf_pkg::ST_WB) begin
      data_mem[{fb_line[7:0], wb_cnt}] <= fb_data[wb_cnt];
    end
  end

  // ==========================================
  // fill buffer and recency
  always_ff @(posedge clk) begin
    if (reset) begin
      fb_line <= 28'h0000000;
      fb_val <= 4'h0;
      fb_nc <= 1'b0;
      mru <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        fb_data[i] <= 32'h0000_0000;
      end
    end else begin
      if (state == icf_pkg::ST_IDLE && inv_all_pend) begin
        fb_val <= 4'h0;
      end
      if (state == icf_pkg::ST_IDLE && !inv_all_pend && line_pend &&
          fb_line[7:0] == line_idx) begin
        fb_val <= 4'h0;
      end
      if (state == icf_pkg::ST_LOOK && look_arr && !look_fbh &&
          req_addr[8:4] == fb_line[4:0]) begin
        mru <= 1'b0;
      end
      if (state == icf_pkg::ST_WB && wb_cnt == 2'h3) begin
        mru <= 1'b0;
      end
      if (ext_start) begin
        fb_line <= req_addr[31:4];
        fb_val <= 4'h0;
        fb_nc <= attr_q.nc;
        mru <= 1'b1;
      end
      if (beat_ok && fb_load) begin
        fb_data[ext_addr[3:2]] <= ext_rdata;
        fb_val[ext_addr[3:2]] <= 1'b1;
      end
    end
  end

  // ==========================================
  // register port
  assign stat = {24'h000000, state == icf_pkg::ST_INV, mru, fb_nc, 1'b0, fb_val};

  always_ff @(posedge clk) begin
    if (reset) begin
      cw <= icf_pkg::CW_RESET;
      ra0 <= icf_pkg::RA_RESET;
      ra1 <= icf_pkg::RA_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        // the invalidate-all bit is a command and is never stored
        icf_pkg::OFF_CTRL: cw <= reg_wdata & icf_pkg::CW_MASK;
        icf_pkg::OFF_RA0: ra0 <= reg_wdata & icf_pkg::RA_MASK;
        icf_pkg::OFF_RA1: ra1 <= reg_wdata & icf_pkg::RA_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        icf_pkg::OFF_CTRL: reg_rdata <= cw;
        icf_pkg::OFF_RA0: reg_rdata <= ra0;
        icf_pkg::OFF_RA1: reg_rdata <= ra1;
        icf_pkg::OFF_STAT: reg_rdata <= stat;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_sram_discard;
    state == icf_pkg::ST_LOOK && req_sram |=> state == icf_pkg::ST_IDLE && !fetch_ack;
  endproperty
  a_sram_discard: assert property (p_sram_discard) else $error("sram fetch not discarded");

  property p_region_order;
    fetch_take && idle_free && !fetch_sram && mi0.hit
      |=> ref_cacheable == !$past(ra0[icf_pkg::RA_NC]);
  endproperty
  a_region_order: assert property (p_region_order) else $error("region 0 not preferred");

  property p_inv_steps;
    state == icf_pkg::ST_INV && inv_cnt != icf_pkg::INV_LAST
      |=> state == icf_pkg::ST_INV && inv_cnt == $past(inv_cnt) + 8'h01 && tag_we;
  endproperty
  a_inv_steps: assert property (p_inv_steps) else $error("invalidate sequence broken");

  property p_inv_stall;
    state == icf_pkg::ST_INV || inv_all_pend |-> !fetch_rdy;
  endproperty
  a_inv_stall: assert property (p_inv_stall) else $error("fetch taken during invalidate");

  property p_line_gate;
    line_inv_core && !line_inv_dbg && cw[icf_pkg::CW_LINV_DIS] && !line_pend |=> !line_pend;
  endproperty
  a_line_gate: assert property (p_line_gate) else $error("line invalidate not gated");

  property p_miss_ext;
    state == icf_pkg::ST_LOOK && look_miss && en && !attr_q.nc |=> ##[0:4] ext_req;
  endproperty
  a_miss_ext: assert property (p_miss_ext) else $error("miss did not fetch");

  property p_wrap;
    beat_ok && !last_beat |=> ext_addr[3:2] == $past(ext_addr[3:2]) + 2'h1 &&
      ext_addr[31:4] == $past(ext_addr[31:4]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("line beat order wrong");

  property p_mru_set;
    ext_start |=> mru && fb_val == 4'h0;
  endproperty
  a_mru_set: assert property (p_mru_set) else $error("recency not set on fill");

  property p_nc_no_wb;
    state == icf_pkg::ST_WB |-> !fb_nc && fb_val == 4'hF;
  endproperty
  a_nc_no_wb: assert property (p_nc_no_wb) else $error("bad buffer write-back");

  property p_disabled_size;
    state == icf_pkg::ST_LOOK && look_miss && !en |=> ext_size != icf_pkg::SZ_LINE && !fb_load;
  endproperty
  a_disabled_size: assert property (p_disabled_size) else $error("burst while disabled");

  property p_nc_single;
    ext_req && !fb_load |-> ##1 $stable(fb_val);
  endproperty
  a_nc_single: assert property (p_nc_single) else $error("buffer touched");

  c_line_fill: cover property (beat_ok && ext_size == icf_pkg::SZ_LINE && beat == 2'h3);
  c_write_back: cover property (state == icf_pkg::ST_WB && wb_cnt == 2'h3);
  c_conc_hit: cover property (fetch_take && conc_ok);
  c_inv_done: cover property (state == icf_pkg::ST_INV && inv_cnt == icf_pkg::INV_LAST);
endmodule // icf_cache_ctrl

// ===== bench/icf_bus_model.sv
`timescale 1ns/1ps
// ==========================================
// external bus controller stand-in
module icf_bus_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] delay,
  input wire logic ext_req,
  input wire logic [31:0] ext_addr,
  output logic ext_ack,
  output logic [31:0] ext_rdata
);
  logic [3:0] wait_cnt;

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_ack <= 1'b0;
      wait_cnt <= 4'h0;
      ext_rdata <= 32'h0;
    end else if (ext_req && !ext_ack && wait_cnt >= delay) begin
      ext_ack <= 1'b1;
      wait_cnt <= 4'h0;
      ext_rdata <= {ext_addr[31:2], 2'b00} ^ 32'h5A5A_0000;
    end else begin
      // data only meaningful with the ack beat, so keep it moving
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (ext_req && !ext_ack) wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // icf_bus_model

// ===== bench/test_icache_fill_and_attributes.sv
`timescale 1ns/1ps
module test_icache_fill_and_attributes;
  // ==========================================
  // signals
  logic clk, reset, reg_wr, reg_rd, fetch_req, fetch_word, fetch_sram, fetch_rdy;
  logic fetch_ack, ref_cacheable, ref_buffered, ref_wprot, dbg_inv_all, line_inv_core;
  logic line_inv_dbg, ext_req, ext_ack;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fetch_addr, fetch_data, line_inv_core_addr;
  logic [31:0] line_inv_dbg_addr, ext_addr, ext_rdata, rd;
  logic [1:0] ext_size;
  logic [3:0] delay;
  int fail_count, n_checks;
  logic [31:0] beats[$];
  logic [1:0] sizes[$];

  icf_cache_ctrl u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fetch_req, .fetch_addr, .fetch_word, .fetch_sram, .fetch_rdy, .fetch_ack, .fetch_data,
    .ref_cacheable, .ref_buffered, .ref_wprot, .dbg_inv_all, .line_inv_core,
    .line_inv_core_addr, .line_inv_dbg, .line_inv_dbg_addr, .ext_req, .ext_addr,
    .ext_size, .ext_ack, .ext_rdata);
  icf_bus_model u_bus (.clk, .reset, .delay, .ext_req, .ext_addr, .ext_ack, .ext_rdata);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(negedge clk) begin
    if (ext_req === 1'b1 && ext_ack === 1'b1) begin
      beats.push_back(ext_addr);
      sizes.push_back(ext_size);
    end
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5A5A_0000;
  endfunction

  function automatic logic [1:0] fill_size(input logic [1:0] sel, input logic [1:0] off);
    if ((sel == 2'h0 && off == 2'h3) || (sel == 2'h1 && off[1])) return icf_pkg::SZ_LONG;
    return icf_pkg::SZ_LINE;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
    @(posedge clk);
  endtask

  task automatic fetch(input logic [31:0] a, input logic w, input logic s);
    int n;
    beats.delete();
    sizes.delete();
    fetch_addr <= a;
    fetch_word <= w;
    fetch_sram <= s;
    fetch_req <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fetch_rdy !== 1'b1 && n < 400);
    @(posedge clk);
    fetch_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fetch_ack !== 1'b1 && n < 40);
    chk("fetch ack", {31'h0, !s}, {31'h0, fetch_ack});
    if (!s) chk("fetch data", mem(a), fetch_data);
    while (ext_req !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    fetch_sram <= 1'b0;
  endtask

  task automatic chk_ext(input logic [31:0] a, input int nb, input logic [1:0] sz);
    chk("beat count", 32'(nb), 32'(beats.size()));
    if (beats.size() == nb) begin
      for (int i = 0; i < nb; i++) begin
        chk("beat addr", {2'h0, a[31:4], 2'(a[3:2] + i)}, {2'h0, beats[i][31:2]});
        chk("beat size", {30'h0, sz}, {30'h0, sizes[i]});
      end
    end
  endtask

  task automatic fx(input logic [31:0] a, input int nb, input logic [1:0] sz);
    fetch(a, 1'b0, 1'b0);
    chk_ext(a, nb, sz);
  endtask

  task automatic inv_all(input logic dbg);
    int n;
    n = 0;
    if (dbg) begin
      dbg_inv_all <= 1'b1;
    end else begin
      reg_addr <= icf_pkg::OFF_CTRL;
      reg_wdata <= 32'h0100_0000;
      reg_wr <= 1'b1;
    end
    @(posedge clk);
    dbg_inv_all <= 1'b0;
    reg_wr <= 1'b0;
    repeat (300) begin
      @(negedge clk);
      if (fetch_rdy !== 1'b1) n++;
    end
    // one pending cycle before the sweep starts
    chk("inv stall", 32'(icf_pkg::INV_CYCLES + 1), 32'(n));
    @(posedge clk);
  endtask

  task automatic pulse_line(input logic dbg, input logic [31:0] a);
    line_inv_core <= !dbg;
    line_inv_dbg <= dbg;
    line_inv_core_addr <= a;
    line_inv_dbg_addr <= a;
    @(posedge clk);
    line_inv_core <= 1'b0;
    line_inv_dbg <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    reg_read(icf_pkg::OFF_CTRL);
    chk("ctrl reset", icf_pkg::CW_RESET, rd);
    chk("rdy reset", 32'h1, {31'h0, fetch_rdy});
    reg_write(icf_pkg::OFF_RA1, 32'hFFFF_FFFF);
    reg_read(icf_pkg::OFF_RA1);
    chk("region1", icf_pkg::RA_MASK, rd);
    // an all-ones region would match every later fetch as noncacheable
    reg_write(icf_pkg::OFF_RA1, 32'h0000_0000);
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_read(8'h10);
    chk("unmapped", 32'h0, rd);
    $display("test regs done");
  endtask

  task automatic t_inv();
    inv_all(1'b0);
    reg_read(icf_pkg::OFF_CTRL);
    chk("inv bit", 32'h0, rd & 32'h0100_0000);
    inv_all(1'b1);
    $display("test inv done");
  endtask

  task automatic t_disabled();
    reg_write(icf_pkg::OFF_CTRL, 32'h0000_0400);
    fetch(32'h2000_0006, 1'b1, 1'b0);
    chk_ext(32'h2000_0006, 1, icf_pkg::SZ_WORD);
    fx(32'h2000_0008, 1, icf_pkg::SZ_LONG);
    $display("test disabled done");
  endtask

  task automatic t_sizes();
    logic [31:0] a;
    logic [1:0] sz;
    for (int s = 0; s < 4; s++) begin
      reg_write(icf_pkg::OFF_CTRL, 32'h8000_0000 | 32'(s));
      for (int o = 0; o < 4; o++) begin
        a = 32'h0001_0000 | 32'(s << 8) | 32'(o << 4) | 32'(o << 2);
        delay <= o[0] ? 4'h3 : 4'h0;
        sz = fill_size(2'(s), 2'(o));
        fx(a, (sz == icf_pkg::SZ_LINE) ? 4 : 1, sz);
      end
    end
    $display("test sizes done");
  endtask

  task automatic t_mru();
    reg_write(icf_pkg::OFF_CTRL, 32'h8000_0002);
    fx(32'h0004_0100, 4, icf_pkg::SZ_LINE);
    reg_read(icf_pkg::OFF_STAT);
    chk("status", 32'h4F, rd & 32'hFF);
    fx(32'h0004_010C, 0, icf_pkg::SZ_LINE);
    fx(32'h0004_0300, 4, icf_pkg::SZ_LINE);
    fx(32'h0004_0104, 0, icf_pkg::SZ_LINE);
    reg_read(icf_pkg::OFF_STAT);
    chk("recency", 32'h0, rd & 32'h40);
    fx(32'h0004_0500, 4, icf_pkg::SZ_LINE);
    fx(32'h0004_0300, 4, icf_pkg::SZ_LINE);
    $display("test mru done");
  endtask

  task automatic t_lineinv();
    pulse_line(1'b0, 32'h0004_0100);
    fx(32'h0004_0100, 4, icf_pkg::SZ_LINE);
    pulse_line(1'b1, 32'h0004_0100);
    fx(32'h0004_0100, 4, icf_pkg::SZ_LINE);
    reg_write(icf_pkg::OFF_CTRL, 32'h9000_0002);
    pulse_line(1'b0, 32'h0004_0300);
    fx(32'h0004_0300, 0, icf_pkg::SZ_LINE);
    $display("test line inv done");
  endtask

  task automatic t_attr();
    logic [31:0] av[3] = '{32'h3000_0000, 32'h3100_0010, 32'h5000_0020};
    logic [2:0] ex[3] = '{3'b000, 3'b110, 3'b111};
    reg_write(icf_pkg::OFF_RA0, 32'h3000_8040);
    reg_write(icf_pkg::OFF_RA1, 32'h300F_8020);
    reg_write(icf_pkg::OFF_CTRL, 32'h8000_0120);
    for (int i = 0; i < 3; i++) begin
      fx(av[i], (i == 0) ? 1 : 4, (i == 0) ? icf_pkg::SZ_LONG : icf_pkg::SZ_LINE);
      chk("attr", {29'h0, ex[i]}, {29'h0, ref_cacheable, ref_buffered, ref_wprot});
    end
    fetch(32'h6000_0000, 1'b0, 1'b1);
    chk_ext(32'h6000_0000, 0, icf_pkg::SZ_LINE);
    reg_write(icf_pkg::OFF_CTRL, 32'h8000_0520);
    fx(32'h3000_0040, 4, icf_pkg::SZ_LINE);
    fx(32'h3000_0048, 0, icf_pkg::SZ_LINE);
    fx(32'h5000_0100, 4, icf_pkg::SZ_LINE);
    // now cacheable, so a wrongly written-back line would hit the array
    reg_write(icf_pkg::OFF_RA0, 32'h0000_0000);
    fx(32'h3000_0040, 4, icf_pkg::SZ_LINE);
    $display("test attr done");
  endtask

  // ==========================================
  // main sequence
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, fetch_req, fetch_word, fetch_sram} = 5'h0;
    {dbg_inv_all, line_inv_core, line_inv_dbg} = 3'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    fetch_addr = 32'h0;
    line_inv_core_addr = 32'h0;
    line_inv_dbg_addr = 32'h0;
    delay = 4'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_inv();
    t_disabled();
    t_sizes();
    t_mru();
    t_lineinv();
    t_attr();
    wrap_up();
  end

  // tests need under two thousand cycles; this is twenty times that
  initial begin
    #2_000_000;
    fail_count++;
    $display("CHECK FAILED watchdog expected done seen hang");
    wrap_up();
  end
endmodule // test_icache_fill_and_attributes
